// File: design/fault_status_telemetry_regs.sv
// Fault flag bytes and read-only telemetry words of a power converter
`timescale 1ns/1ps
`default_nettype none
module fault_status_telemetry_regs
  import fault_telemetry_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  output logic             rsp_valid_ff,
  output logic             rsp_two_ff,
  output logic             rsp_err_ff,
  output logic [15:0]      rsp_data_ff,
  input  wire logic [7:0]  input_evt,
  input  wire logic        vin_above_on,
  input  wire logic        vin_below_off,
  input  wire logic [7:0]  temp_evt,
  input  wire logic [7:0]  comm_evt,
  input  wire logic [7:0]  misc_evt,
  input  wire logic [7:0]  vendor_evt,
  input  wire logic [7:0]  output_voltage_format_setting,
  input  wire logic [15:0] supply_voltage_reading,
  input  wire logic [15:0] supply_current_reading,
  input  wire logic [15:0] holdup_cap_voltage_reading,
  input  wire logic [15:0] output_voltage_reading,
  input  wire logic [15:0] output_current_reading,
  input  wire logic [15:0] temp_reading_one,
  input  wire logic [15:0] temp_reading_two,
  input  wire logic [15:0] temp_reading_three,
  input  wire logic [15:0] fan_speed_reading_one,
  input  wire logic [15:0] fan_speed_reading_two,
  input  wire logic [15:0] fan_supply_reading_one,
  input  wire logic [15:0] fan_supply_reading_two,
  input  wire logic [15:0] duty_cycle_reading,
  input  wire logic [15:0] switch_freq_reading,
  output logic [7:0]       input_fault_flags_ff,
  output logic [7:0]       temperature_fault_flags_ff,
  output logic [7:0]       comm_logic_fault_flags_ff,
  output logic [7:0]       misc_hardware_fault_flags_ff,
  output logic [7:0]       vendor_fault_flags_ff,
  output logic             comm_logic_summary_bit_ff,
  output logic             input_summary_bit_ff
);

  // ****************************************
  // Command decode
  // ****************************************
  logic        is_flag_cmd;
  logic        is_meas_cmd;
  logic [15:0] meas_word;
  logic [7:0]  flag_byte;
  logic        bad_cmd;
  logic        bad_data;
  logic [15:0] vout_word;

  // Sort the code into flag byte, measurement word or unknown
  always_comb begin
    is_flag_cmd = 1'b1;
    is_meas_cmd = 1'b0;
    flag_byte   = 8'h00;
    meas_word   = WORD_ZERO;
    unique case (cmd_code)
      CMD_INPUT_FLAGS:  flag_byte = input_fault_flags_ff;
      CMD_TEMP_FLAGS:   flag_byte = temperature_fault_flags_ff;
      CMD_COMM_FLAGS:   flag_byte = comm_logic_fault_flags_ff;
      CMD_MISC_FLAGS:   flag_byte = misc_hardware_fault_flags_ff;
      CMD_VENDOR_FLAGS: flag_byte = vendor_fault_flags_ff;
      default: begin
        is_flag_cmd = 1'b0;
        is_meas_cmd = 1'b1;
        unique case (cmd_code)
          CMD_VIN:        meas_word = supply_voltage_reading;
          CMD_IIN:        meas_word = supply_current_reading;
          CMD_VCAP:       meas_word = holdup_cap_voltage_reading;
          CMD_VOUT:       meas_word = vout_word;
          CMD_IOUT:       meas_word = output_current_reading;
          CMD_TEMP1:      meas_word = temp_reading_one;
          CMD_TEMP2:      meas_word = temp_reading_two;
          CMD_TEMP3:      meas_word = temp_reading_three;
          CMD_FAN_SPEED1: meas_word = fan_speed_reading_one;
          CMD_FAN_SPEED2: meas_word = fan_speed_reading_two;
          CMD_FAN_VOLT1:  meas_word = fan_supply_reading_one;
          CMD_FAN_VOLT2:  meas_word = fan_supply_reading_two;
          CMD_DUTY:       meas_word = duty_cycle_reading;
          CMD_FREQ:       meas_word = switch_freq_reading;
          default:        is_meas_cmd = 1'b0;
        endcase
      end
    endcase
  end

  // Unknown codes and any write are refused; writes cannot reach a reading
  assign bad_cmd  = cmd_valid && !is_flag_cmd && !is_meas_cmd;
  assign bad_data = cmd_valid && cmd_write && !bad_cmd;

  // ****************************************
  // Output voltage format
  // ****************************************
  logic [16:0] idc_offset;
  logic [16:0] idc_code;

  // Nearest id code: round half a step up, clamp at both ends
  always_comb begin
    idc_offset = {1'b0, output_voltage_reading} - {1'b0, IDCODE_BASE}
               + {2'b00, IDCODE_STEP[15:1]};
    if (output_voltage_reading < IDCODE_BASE) begin
      idc_code = 17'h00000;
    end else begin
      idc_code = idc_offset / {1'b0, IDCODE_STEP};
    end
    if (idc_code > IDCODE_MAX) begin
      idc_code = IDCODE_MAX;
    end
    if (output_voltage_format_setting[7:5] == VOUT_FMT_IDCODE) begin
      vout_word = {8'h00, idc_code[7:0]};
    end else begin
      vout_word = output_voltage_reading;
    end
  end

  // ****************************************
  // Response register
  // ****************************************
  // One-cycle answer; data is sampled with the request so it cannot tear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_two_ff   <= 1'b0;
      rsp_err_ff   <= 1'b0;
      rsp_data_ff  <= WORD_ZERO;
    end else begin
      rsp_valid_ff <= cmd_valid;
      rsp_two_ff   <= cmd_valid && is_meas_cmd && !cmd_write;
      rsp_err_ff   <= bad_cmd || bad_data;
      if (cmd_valid && !cmd_write && is_meas_cmd) begin
        rsp_data_ff <= meas_word;
      end else if (cmd_valid && !cmd_write && is_flag_cmd) begin
        rsp_data_ff <= {8'h00, flag_byte};
      end else begin
        rsp_data_ff <= WORD_ZERO;
      end
    end
  end

  // ****************************************
  // Insufficient input tracking
  // ****************************************
  logic started_ff;
  logic insuff;

  // Remember that input once passed turn-on; cleared when it drops out
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      started_ff <= 1'b0;
    end else if (vin_above_on) begin
      started_ff <= 1'b1;
    end else if (vin_below_off) begin
      started_ff <= 1'b0;
    end
  end

  // A live state rather than a sticky flag: it tracks the unit being off
  assign insuff = !started_ff || vin_below_off;

  // ****************************************
  // Sticky flag bytes
  // ****************************************
  logic [7:0] nxt_input_flags;
  logic [7:0] nxt_comm_flags;
  logic [7:0] comm_set;

  // Internal refusals merge with external comm events in one set vector
  assign comm_set = (comm_evt & COMM_MASK)
                  | ({7'h00, bad_cmd} << COMM_BAD_CMD_BIT)
                  | ({7'h00, bad_data} << COMM_BAD_DATA_BIT);

  // Flags only set here, except the insufficient-input bit, which follows insuff; clearing belongs to a block outside this one
  always_comb begin
    nxt_input_flags = (input_fault_flags_ff | input_evt) & INPUT_EVT_MASK;
    nxt_input_flags[INSUFF_BIT] = insuff;
    nxt_comm_flags = comm_logic_fault_flags_ff | comm_set;
  end

  // Per-class capture; reserved bits are masked so they read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      input_fault_flags_ff         <= FLAGS_RESET;
      temperature_fault_flags_ff   <= FLAGS_RESET;
      comm_logic_fault_flags_ff    <= FLAGS_RESET;
      misc_hardware_fault_flags_ff <= FLAGS_RESET;
      vendor_fault_flags_ff        <= FLAGS_RESET;
    end else begin
      input_fault_flags_ff         <= nxt_input_flags;
      temperature_fault_flags_ff   <= temperature_fault_flags_ff
                                      | (temp_evt & TEMP_MASK);
      comm_logic_fault_flags_ff    <= nxt_comm_flags;
      // Fan, fuse, OR-ing and unknown faults keep their bit positions
      misc_hardware_fault_flags_ff <= misc_hardware_fault_flags_ff
                                      | (misc_evt & MISC_MASK);
      vendor_fault_flags_ff        <= vendor_fault_flags_ff
                                      | (vendor_evt & VENDOR_MASK);
    end
  end

  // ****************************************
  // Summary bits
  // ****************************************
  // Built from next values so they move in step with the flag bytes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      comm_logic_summary_bit_ff <= 1'b0;
      input_summary_bit_ff      <= 1'b0;
    end else begin
      comm_logic_summary_bit_ff <= |nxt_comm_flags;
      input_summary_bit_ff      <= |(nxt_input_flags & ~(8'h01 << INSUFF_BIT));
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence rd_of(logic [7:0] code);
    cmd_valid && !cmd_write && cmd_code == code;
  endsequence

  sequence wr_meas;
    cmd_valid && cmd_write && is_meas_cmd;
  endsequence

  chk_input_ov_sticky: assert property (
    input_evt[7] |=> input_fault_flags_ff[7] [*3])
    else $error("input OV flag not held");

  chk_insuff_state: assert property (
    (!started_ff && !vin_above_on) |=> input_fault_flags_ff[INSUFF_BIT])
    else $error("insufficient input flag missing");

  chk_input_reserved: assert property (
    input_fault_flags_ff[0] == 1'b0)
    else $error("input reserved bit set");

  chk_temp_reserved: assert property (
    temperature_fault_flags_ff[3:0] == 4'h0)
    else $error("temperature reserved bits set");

  chk_bad_cmd_flag: assert property (
    bad_cmd |=> rsp_err_ff && comm_logic_fault_flags_ff[COMM_BAD_CMD_BIT] && comm_logic_summary_bit_ff)
    else $error("bad command not flagged");

  chk_ro_write: assert property (
    wr_meas |=> rsp_err_ff && !rsp_two_ff && comm_logic_fault_flags_ff[COMM_BAD_DATA_BIT])
    else $error("write to reading accepted");

  chk_vin_word: assert property (
    rd_of(CMD_VIN) |=> rsp_two_ff && rsp_data_ff == $past(supply_voltage_reading))
    else $error("input voltage word wrong");

  chk_idcode_mode: assert property (
    rd_of(CMD_VOUT) && output_voltage_format_setting[7:5] == VOUT_FMT_IDCODE
    |=> rsp_data_ff[15:8] == 8'h00 && rsp_data_ff[7:0] == $past(idc_code[7:0]))
    else $error("id code wrong");

  chk_cml_summary: assert property (
    comm_logic_summary_bit_ff == (comm_logic_fault_flags_ff != 8'h00))
    else $error("comm summary mismatch");

  chk_input_summary: assert property (
    input_evt[2] |=> input_summary_bit_ff [*2])
    else $error("input summary not set");

  // A flag read answers with one byte, upper byte zero
  sequence flag_rd_any;
    cmd_valid && !cmd_write && is_flag_cmd;
  endsequence

  // Unit had started, then input dropped below turn-off
  sequence drop_out;
    started_ff ##1 (!vin_above_on && vin_below_off);
  endsequence

  chk_flag_byte_rd: assert property (
    flag_rd_any |=> rsp_valid_ff && !rsp_two_ff && !rsp_err_ff && rsp_data_ff[15:8] == 8'h00)
    else $error("flag read answer malformed");

  chk_rsp_follows: assert property (
    cmd_valid |=> rsp_valid_ff)
    else $error("request not answered");

  chk_rsp_one_cycle: assert property (
    !cmd_valid |=> !rsp_valid_ff && !rsp_two_ff && !rsp_err_ff)
    else $error("answer without request");

  chk_insuff_drop: assert property (
    drop_out |=> input_fault_flags_ff[INSUFF_BIT])
    else $error("drop-out not flagged");

  chk_input_oc: assert property (
    input_evt[1] |=> input_fault_flags_ff[1] && input_summary_bit_ff)
    else $error("input overcurrent warning missing");

  chk_pec_flag: assert property (
    comm_evt[5] |=> comm_logic_fault_flags_ff[5])
    else $error("packet check flag missing");

  chk_comm_reserved: assert property (
    comm_logic_fault_flags_ff[2] == 1'b0)
    else $error("comm reserved bit set");

  chk_misc_sticky: assert property (
    misc_evt[0] |=> misc_hardware_fault_flags_ff[0] [*3])
    else $error("unknown fault flag not held");

  chk_temp_sticky: assert property (
    temp_evt[7] |=> temperature_fault_flags_ff[7] [*4])
    else $error("overtemperature flag not held");

  chk_vout_raw: assert property (
    rd_of(CMD_VOUT) && output_voltage_format_setting[7:5] != VOUT_FMT_IDCODE
    |=> rsp_data_ff == $past(output_voltage_reading))
    else $error("output voltage word wrong");

  chk_freq_word: assert property (
    rd_of(CMD_FREQ) |=> rsp_two_ff && rsp_data_ff == $past(switch_freq_reading))
    else $error("frequency word wrong");

endmodule : fault_status_telemetry_regs
`default_nettype wire

// File: design/fault_telemetry_pkg.sv
// Constants shared by the fault status and telemetry register set
package fault_telemetry_pkg;

  // ****************************************
  // Command codes of the read port
  // ****************************************
  localparam logic [7:0] CMD_INPUT_FLAGS  = 8'h10;
  localparam logic [7:0] CMD_TEMP_FLAGS   = 8'h11;
  localparam logic [7:0] CMD_COMM_FLAGS   = 8'h12;
  localparam logic [7:0] CMD_MISC_FLAGS   = 8'h13;
  localparam logic [7:0] CMD_VENDOR_FLAGS = 8'h14;
  localparam logic [7:0] CMD_VIN          = 8'h20;
  localparam logic [7:0] CMD_IIN          = 8'h21;
  localparam logic [7:0] CMD_VCAP         = 8'h22;
  localparam logic [7:0] CMD_VOUT         = 8'h23;
  localparam logic [7:0] CMD_IOUT         = 8'h24;
  localparam logic [7:0] CMD_TEMP1        = 8'h25;
  localparam logic [7:0] CMD_TEMP2        = 8'h26;
  localparam logic [7:0] CMD_TEMP3        = 8'h27;
  localparam logic [7:0] CMD_FAN_SPEED1   = 8'h28;
  localparam logic [7:0] CMD_FAN_SPEED2   = 8'h29;
  localparam logic [7:0] CMD_FAN_VOLT1    = 8'h2A;
  localparam logic [7:0] CMD_FAN_VOLT2    = 8'h2B;
  localparam logic [7:0] CMD_DUTY         = 8'h2C;
  localparam logic [7:0] CMD_FREQ         = 8'h2D;

  // ****************************************
  // Implemented bits of each flag byte
  // ****************************************
  localparam logic [7:0] INPUT_EVT_MASK  = 8'hF6;
  localparam logic [7:0] TEMP_MASK       = 8'hF0;
  localparam logic [7:0] COMM_MASK       = 8'hFB;
  localparam logic [7:0] MISC_MASK       = 8'hFF;
  localparam logic [7:0] VENDOR_MASK     = 8'hFF;
  localparam logic [7:0] FLAGS_RESET     = 8'h00;
  localparam int         INSUFF_BIT      = 3;
  localparam int         COMM_BAD_CMD_BIT  = 7;
  localparam int         COMM_BAD_DATA_BIT = 6;

  // ****************************************
  // Output voltage format and id code mapping
  // ****************************************
  localparam logic [2:0]  VOUT_FMT_IDCODE = 3'h1;
  localparam logic [15:0] IDCODE_BASE     = 16'h0100;
  localparam logic [15:0] IDCODE_STEP     = 16'h0010;
  localparam logic [16:0] IDCODE_MAX      = 17'h000FF;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;

endpackage : fault_telemetry_pkg

// File: sim/host_reader_model.sv
// Host model that issues one read or write request at a time
`timescale 1ns/1ps
`default_nettype none
module host_reader_model (
  input  wire logic        core_clk,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  input  wire logic        rsp_valid_ff,
  input  wire logic        rsp_two_ff,
  input  wire logic        rsp_err_ff,
  input  wire logic [15:0] rsp_data_ff
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
  end

  // ****************************************
  // One request, answer taken one edge after
  // ****************************************
  task automatic access(input logic wr, input logic [7:0] code,
                        output logic [2:0] flags, output logic [15:0] data);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code  <= code;
    @(posedge core_clk);
    // Idle code is scrambled so a stale value never looks valid
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;
    // Answer stands one cycle; take it mid-cycle, clear of the launch edge
    @(negedge core_clk);
    flags = {rsp_valid_ff, rsp_two_ff, rsp_err_ff};
    data  = rsp_data_ff;
  endtask : access
endmodule : host_reader_model
`default_nettype wire

// File: sim/tb_fault_status_telemetry_regs.sv
// Self-checking bench of the fault flag and telemetry register set
`timescale 1ns/1ps
`default_nettype none
module tb_fault_status_telemetry_regs;
  import fault_telemetry_pkg::*;
  typedef struct packed {logic [7:0] code; logic [15:0] exp;} row_t;
  logic        core_clk = 1'b0;
  logic        rst_n;
  logic        cmd_valid, cmd_write, rsp_valid_ff, rsp_two_ff, rsp_err_ff;
  logic [7:0]  cmd_code, input_evt, temp_evt, comm_evt, misc_evt, vendor_evt, fmt;
  logic        vin_above_on, vin_below_off;
  logic [15:0] rsp_data_ff, data;
  logic [15:0] rd [14];
  logic [2:0]  fl;
  logic [7:0]  inf, tf, cf, mf, vf;
  logic        cs, is;
  row_t        rows [14];
  logic [7:0]  flag_exp [5] = '{8'hF6, 8'hF0, 8'h3B, 8'hFF, 8'hA5};
  int          error_cnt = 0;
  int          cmp_count = 0;

  always #50 core_clk = ~core_clk;

  fault_status_telemetry_regs u_fault_status_telemetry_regs (
    .core_clk, .rst_n, .cmd_valid, .cmd_write, .cmd_code,
    .rsp_valid_ff, .rsp_two_ff, .rsp_err_ff, .rsp_data_ff,
    .input_evt, .vin_above_on, .vin_below_off, .temp_evt, .comm_evt,
    .misc_evt, .vendor_evt, .output_voltage_format_setting(fmt),
    .supply_voltage_reading(rd[0]), .supply_current_reading(rd[1]),
    .holdup_cap_voltage_reading(rd[2]), .output_voltage_reading(rd[3]),
    .output_current_reading(rd[4]), .temp_reading_one(rd[5]),
    .temp_reading_two(rd[6]), .temp_reading_three(rd[7]),
    .fan_speed_reading_one(rd[8]), .fan_speed_reading_two(rd[9]),
    .fan_supply_reading_one(rd[10]), .fan_supply_reading_two(rd[11]),
    .duty_cycle_reading(rd[12]), .switch_freq_reading(rd[13]),
    .input_fault_flags_ff(inf), .temperature_fault_flags_ff(tf),
    .comm_logic_fault_flags_ff(cf), .misc_hardware_fault_flags_ff(mf),
    .vendor_fault_flags_ff(vf), .comm_logic_summary_bit_ff(cs),
    .input_summary_bit_ff(is)
  );

  host_reader_model u_host_reader_model (
    .core_clk, .cmd_valid, .cmd_write, .cmd_code,
    .rsp_valid_ff, .rsp_two_ff, .rsp_err_ff, .rsp_data_ff
  );

  // ****************************************
  // Compare and close
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic rd_cmd(input logic wr, input logic [7:0] code);
    u_host_reader_model.access(wr, code, fl, data);
  endtask : rd_cmd

  // Run takes under a hundred cycles, so this only trips on a hang
  initial begin
    #(100 * 5000);
    error_cnt++;
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {input_evt, temp_evt, comm_evt, misc_evt, vendor_evt, fmt} = '0;
    {vin_above_on, vin_below_off} = 2'b00;
    for (int i = 0; i < 14; i++) begin
      rows[i] = '{CMD_VIN + 8'(i), 16'hC300 ^ (16'h0111 * 16'(i))};
      rd[i] = rows[i].exp;
    end
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check("input flags at reset", {8'h00, inf}, 16'h0008);
    check("temp and comm at reset", {tf, cf}, 16'h0000);
    check("misc and vendor at reset", {mf, vf}, 16'h0000);
    check("summaries at reset", {14'h0, cs, is}, 16'h0000);
    // Start the unit so the insufficient-input state clears
    @(posedge core_clk) vin_above_on <= 1'b1;
    @(posedge core_clk) vin_above_on <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check("input flags started", {8'h00, inf}, 16'h0000);
    // Every measurement word, table driven
    for (int i = 0; i < 14; i++) begin
      rd_cmd(1'b0, rows[i].code);
      check("reading word", data, rows[i].exp);
      check("reading strobes", {13'h0, fl}, 16'h0006);
    end
    // One-cycle events; reserved bits must not stick
    @(posedge core_clk);
    {input_evt, temp_evt, comm_evt, misc_evt, vendor_evt} <= {32'hFFFF3FFF, 8'hA5};
    @(posedge core_clk);
    {input_evt, temp_evt, comm_evt, misc_evt, vendor_evt} <= '0;
    repeat (3) @(posedge core_clk);
    #1;
    check("summaries set", {14'h0, cs, is}, 16'h0003);
    for (int j = 0; j < 5; j++) begin
      rd_cmd(1'b0, CMD_INPUT_FLAGS + 8'(j));
      check("flag byte", data, {8'h00, flag_exp[j]});
      check("flag strobes", {13'h0, fl}, 16'h0004);
    end
    // Write to a measurement is refused and leaves the reading unchanged
    rd_cmd(1'b1, CMD_VIN);
    check("write refused", {13'h0, fl}, 16'h0005);
    check("write data", data, 16'h0000);
    rd_cmd(1'b0, CMD_VIN);
    check("vin after write", data, rows[0].exp);
    rd_cmd(1'b0, CMD_COMM_FLAGS);
    check("bad data flag", data, 16'h007B);
    rd_cmd(1'b0, 8'h55);
    check("unknown refused", {13'h0, fl}, 16'h0005);
    rd_cmd(1'b0, CMD_COMM_FLAGS);
    check("bad command flag", data, 16'h00FB);
    // Input falls below turn-off after the start
    @(posedge core_clk) vin_below_off <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check("input off", {8'h00, inf}, 16'h00FE);
    // Identification format: nearest code, and floor at base
    @(posedge core_clk);
    fmt   <= 8'h20;
    rd[3] <= 16'h0159;
    rd_cmd(1'b0, CMD_VOUT);
    check("id code nearest", data, 16'h0006);
    @(posedge core_clk) rd[3] <= 16'h0050;
    rd_cmd(1'b0, CMD_VOUT);
    check("id code below base", data, 16'h0000);
    // Mid-run reset clears sticky flags; insufficient input shows again
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check("flags after reset", {inf, cf}, 16'h0800);
    report_and_stop();
  end
endmodule : tb_fault_status_telemetry_regs
`default_nettype wire
